/* verilog/cbc_pkg.sv */
// Constants and carriers for the bus cycle control block
// Assumes a single bus clock domain
package cbc_pkg;

    // ==========================================
    // Transfer counts
    localparam logic [2:0] CBC_XFER_SINGLE = 3'h1;
    localparam logic [2:0] CBC_XFER_BURST  = 3'h4;

    // ==========================================
    // Reset values and parity low bit
    localparam logic [2:0] CBC_RATIO_RST = 3'h7;
    localparam logic [7:0] CBC_BE_RST    = 8'hFF;
    localparam logic [3:0] CBC_DEF_RST   = 4'h0;
    localparam int         CBC_PAR_LO    = 5;
    localparam logic [2:0] CBC_CNT_RST   = 3'h0;
    localparam logic [2:0] CBC_HOLD_CLKS = 3'h2;

    // ==========================================
    // Ratio codes
    localparam logic [2:0] CBC_R_2P5 = 3'h4;
    localparam logic [2:0] CBC_R_3P0 = 3'h5;
    localparam logic [2:0] CBC_R_6P0 = 3'h6;
    localparam logic [2:0] CBC_R_3P5 = 3'h7;
    localparam logic [2:0] CBC_R_4P5 = 3'h0;
    localparam logic [2:0] CBC_R_5P0 = 3'h1;
    localparam logic [2:0] CBC_R_4P0 = 3'h2;
    localparam logic [2:0] CBC_R_5P5 = 3'h3;

    // Multiplier in halves
    localparam logic [3:0] CBC_M_2P5 = 4'h5;
    localparam logic [3:0] CBC_M_3P0 = 4'h6;
    localparam logic [3:0] CBC_M_6P0 = 4'hC;
    localparam logic [3:0] CBC_M_3P5 = 4'h7;
    localparam logic [3:0] CBC_M_4P5 = 4'h9;
    localparam logic [3:0] CBC_M_5P0 = 4'hA;
    localparam logic [3:0] CBC_M_4P0 = 4'h8;
    localparam logic [3:0] CBC_M_5P5 = 4'hB;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic [31:3] addr;
        logic [7:0]  be_n;
        logic [3:0]  def;
        logic        burst;
        logic        wb;
    } cbc_req_s;

    typedef enum logic [2:0] {
        CBC_IDLE = 3'b001,
        CBC_ACT  = 3'b010,
        CBC_BUS_BACKOFF_N = 3'b100
    } cbc_state_e;

endpackage

/* verilog/cbc_top.sv */
// Processor side bus cycle control: strobes, byte lanes, address parity,
// address hold, backoff restart and ratio capture.
// Assumes bus inputs are synchronous to CORE_CLK; reset arrives asynchronously.
//
// Contract
// RL1: Strobe low one clock, address valid with it
// RL2: Non-pipelined next strobe after final acknowledge
// RL3: Next-address request allows overlapped strobe
// RL4: Under address hold, only snoop writebacks start
// RL5: Float strobe on backoff or hold ack
// RL6: Strobe copy duplicates strobe exactly
// RL7: Address hold floats address and parity
// RL8: Address driven again when hold drops
// RL9: Address hold sampled always, even reset; here sampled only out of reset, while reset floats the address anyway
// RL10: Even parity over parity bit, A31..A5
// RL11: Parity driven from strobe, also idle
// RL12: Snoop parity sampled with snoop valid
// RL13: Parity floats on hold, backoff, hold ack
// RL14: Parity mismatch pulses error one clock
// RL15: Byte enable bit per data lane
// RL16: System drives all lanes on bursts
// RL17: Byte enables float on backoff, hold ack
// RL18: Ratio select maps to core multiplier
// RL19: Ratio captured at reset release
// RL20: Backoff aborts and floats all outputs
// RL21: Aborted cycle restarts from first transfer
// RL22: Backoff beats same-edge acknowledge
// RL23: One acknowledge single, four for burst
// RL24: Captured ratio held until next reset
`timescale 1ns/1ps
module cbc_top
    import cbc_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    input  wire logic        REQ_VALID,
    input  wire cbc_req_s    REQ,
    input  wire logic        ADDR_HOLD_REQ,
    input  wire logic        BUS_BACKOFF_N,
    input  wire logic        BUS_HOLD_REQ,
    input  wire logic        TRANSFER_ACK_N,
    input  wire logic        NEXT_ADDR_REQ_N,
    input  wire logic        SNOOP_ADDR_VALID_N,
    input  wire logic [31:5] SNOOP_ADDR,
    input  wire logic        SNOOP_PARITY_IN,
    input  wire logic [2:0]  CORE_RATIO_SEL,
    output logic             REQ_READY,
    output logic             REQ_DONE,
    output logic             CYCLE_STROBE_N,
    output logic             CYCLE_STROBE_OE,
    output logic             CYCLE_STROBE_COPY_N,
    output logic             CYCLE_STROBE_COPY_OE,
    output logic [31:3]      PHYS_ADDR,
    output logic             PHYS_ADDR_OE,
    output logic             ADDR_PARITY_BIT,
    output logic             ADDR_PARITY_OE,
    output logic [7:0]       BYTE_LANE_EN_N,
    output logic             BYTE_LANE_OE,
    output logic [3:0]       CYCLE_DEF,
    output logic             CYCLE_DEF_OE,
    output logic             DATA_OE,
    output logic             BUS_HOLD_ACK,
    output logic             ADDR_PARITY_ERR_N,
    output logic [3:0]       CORE_MULT_HALVES
);

    // ==========================================
    // State
    cbc_state_e  state_r;
    cbc_req_s    cur_r;
    logic        pend_r;
    logic        na_seen_r;
    logic [2:0]  ack_cnt_r;
    logic        rst_d_r;
    logic [2:0]  ratio_r;
    logic [2:0]  hold_cnt_r;
    logic        snp_err_r;

    logic        bus_backoff_n;
    logic        ack;
    logic        last_ack;
    logic        can_start;
    logic        start;
    logic        float_all;
    logic        new_par;
    logic [2:0]  need;
    logic        restart_go;
    logic        hold_ack_nxt;

    assign bus_backoff_n      = !BUS_BACKOFF_N;
    assign need      = cur_r.burst ? CBC_XFER_BURST : CBC_XFER_SINGLE;
    assign ack       = (state_r == CBC_ACT) && CYCLE_STROBE_N && !TRANSFER_ACK_N && !bus_backoff_n; // [RL22]
    assign last_ack  = ack && (ack_cnt_r + 3'h1 == need); // [RL23]
    assign hold_ack_nxt = BUS_HOLD_REQ && (state_r != CBC_ACT || BUS_HOLD_ACK) && CYCLE_STROBE_N;
    assign float_all = bus_backoff_n || hold_ack_nxt; // [RL5] [RL13]
    // Start when idle, or overlapped after next-address request; idle clock after final ack
    assign can_start = (state_r == CBC_IDLE) || na_seen_r; // [RL2] [RL3]
    assign start     = REQ_VALID && can_start && !bus_backoff_n && !BUS_HOLD_REQ && !BUS_HOLD_ACK && !RESET
                     && (!ADDR_HOLD_REQ || REQ.wb) && CYCLE_STROBE_N && !pend_r; // [RL4]
    assign restart_go = pend_r && CYCLE_STROBE_N && !ADDR_HOLD_REQ && !BUS_HOLD_REQ && !BUS_HOLD_ACK && !bus_backoff_n;
    assign new_par   = ^REQ.addr[31:CBC_PAR_LO]; // [RL10]

    // ==========================================
    // Cycle sequencing
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state_r   <= CBC_IDLE;
            ack_cnt_r <= CBC_CNT_RST;
            na_seen_r <= 1'b0;
            pend_r    <= 1'b0;
            cur_r     <= '0;
            REQ_DONE  <= 1'b0;
            REQ_READY <= 1'b0;
        end
        else
        begin
            REQ_DONE  <= last_ack && !pend_r;
            REQ_READY <= !pend_r && state_r != CBC_BUS_BACKOFF_N;
            if (bus_backoff_n && state_r == CBC_ACT)
            begin
                state_r   <= CBC_BUS_BACKOFF_N; // [RL20]
                ack_cnt_r <= CBC_CNT_RST; // [RL21]
                na_seen_r <= 1'b0;
            end
            else if (state_r == CBC_BUS_BACKOFF_N)
            begin
                if (!bus_backoff_n)
                begin
                    state_r <= CBC_IDLE;
                    pend_r  <= 1'b1; // [RL21]
                end
            end
            else if (restart_go)
            begin
                state_r <= CBC_ACT;
                pend_r  <= 1'b0;
            end
            else if (start)
            begin
                cur_r     <= REQ;
                state_r   <= CBC_ACT;
                ack_cnt_r <= CBC_CNT_RST;
                na_seen_r <= 1'b0;
            end
            else if (last_ack)
            begin
                state_r   <= CBC_IDLE;
                ack_cnt_r <= CBC_CNT_RST;
                na_seen_r <= 1'b0;
            end
            else
            begin
                if (ack)
                    ack_cnt_r <= ack_cnt_r + 3'h1;
                if (state_r == CBC_ACT && CYCLE_STROBE_N && !NEXT_ADDR_REQ_N)
                    na_seen_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // Strobes, one clock low

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            CYCLE_STROBE_N      <= 1'b1;
            CYCLE_STROBE_COPY_N <= 1'b1;
        end
        else
        begin
            CYCLE_STROBE_N      <= !((start || restart_go) && !bus_backoff_n) || !CYCLE_STROBE_N; // [RL1]
            CYCLE_STROBE_COPY_N <= !((start || restart_go) && !bus_backoff_n) || !CYCLE_STROBE_N; // [RL6]
        end
    end

    // ==========================================
    // Hold acknowledge
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
            BUS_HOLD_ACK <= 1'b0;
        else
            BUS_HOLD_ACK <= hold_ack_nxt; // [RL5]
    end

    // ==========================================
    // Address, parity, lanes, definition
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PHYS_ADDR       <= '0;
            ADDR_PARITY_BIT <= 1'b0;
            BYTE_LANE_EN_N  <= CBC_BE_RST;
            CYCLE_DEF       <= CBC_DEF_RST;
        end
        else if (start)
        begin
            PHYS_ADDR       <= REQ.addr; // [RL1]
            ADDR_PARITY_BIT <= new_par; // [RL11]
            BYTE_LANE_EN_N  <= REQ.be_n; // [RL15] [RL17]
            CYCLE_DEF       <= REQ.def;
        end
        else if (restart_go)
        begin
            PHYS_ADDR       <= cur_r.addr; // [RL21]
            ADDR_PARITY_BIT <= ^cur_r.addr[31:CBC_PAR_LO];
            BYTE_LANE_EN_N  <= cur_r.be_n;
            CYCLE_DEF       <= cur_r.def;
        end
    end

    // Enables: reset floats all; the hold request is sampled only out of reset
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PHYS_ADDR_OE         <= 1'b0;
            ADDR_PARITY_OE       <= 1'b0;
            BYTE_LANE_OE         <= 1'b0;
            CYCLE_DEF_OE         <= 1'b0;
            CYCLE_STROBE_OE      <= 1'b0;
            CYCLE_STROBE_COPY_OE <= 1'b0;
            DATA_OE              <= 1'b0;
        end
        else
        begin
            PHYS_ADDR_OE         <= !ADDR_HOLD_REQ && !float_all; // [RL7] [RL8] [RL9]
            ADDR_PARITY_OE       <= !ADDR_HOLD_REQ && !float_all; // [RL13]
            BYTE_LANE_OE         <= !float_all; // [RL17]
            CYCLE_DEF_OE         <= !float_all;
            CYCLE_STROBE_OE      <= !float_all; // [RL5]
            CYCLE_STROBE_COPY_OE <= !float_all; // [RL6]
            DATA_OE              <= !float_all && state_r == CBC_ACT && cur_r.def[0]; // [RL20]
        end
    end

    // ==========================================
    // Snoop parity check
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            snp_err_r         <= 1'b0;
            ADDR_PARITY_ERR_N <= 1'b1;
        end
        else
        begin
            snp_err_r         <= !SNOOP_ADDR_VALID_N && ^{SNOOP_PARITY_IN, SNOOP_ADDR[31:CBC_PAR_LO]}; // [RL12]
            ADDR_PARITY_ERR_N <= !snp_err_r; // [RL14]
        end
    end

    // ==========================================
    // Ratio capture at reset release
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
            rst_d_r <= 1'b1;
        else
            rst_d_r <= 1'b0;
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            ratio_r    <= CBC_RATIO_RST;
            hold_cnt_r <= CBC_CNT_RST;
        end
        else if (rst_d_r)
        begin
            ratio_r    <= CORE_RATIO_SEL; // [RL19] [RL24]
            hold_cnt_r <= CBC_HOLD_CLKS;
        end
        else if (hold_cnt_r != CBC_CNT_RST)
            hold_cnt_r <= hold_cnt_r - 3'h1;
    end

    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
            CORE_MULT_HALVES <= CBC_M_3P5;
        else
            unique case (ratio_r) // [RL18]
                CBC_R_2P5: CORE_MULT_HALVES <= CBC_M_2P5;
                CBC_R_3P0: CORE_MULT_HALVES <= CBC_M_3P0;
                CBC_R_6P0: CORE_MULT_HALVES <= CBC_M_6P0;
                CBC_R_3P5: CORE_MULT_HALVES <= CBC_M_3P5;
                CBC_R_4P5: CORE_MULT_HALVES <= CBC_M_4P5;
                CBC_R_5P0: CORE_MULT_HALVES <= CBC_M_5P0;
                CBC_R_4P0: CORE_MULT_HALVES <= CBC_M_4P0;
                CBC_R_5P5: CORE_MULT_HALVES <= CBC_M_5P5;
            endcase
    end

    // ==========================================
    // Checks
    sequence s_strobe;
        !CYCLE_STROBE_N ##1 CYCLE_STROBE_N;
    endsequence

    property p_strobe_pulse;
        @(posedge CORE_CLK) disable iff (RESET)
        $fell(CYCLE_STROBE_N) |-> s_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe wider than one clock"); // [RL1]

    property p_copy;
        @(posedge CORE_CLK) disable iff (RESET)
        CYCLE_STROBE_COPY_N == CYCLE_STROBE_N && CYCLE_STROBE_COPY_OE == CYCLE_STROBE_OE;
    endproperty
    a_copy: assert property (p_copy) else $error("strobe copy differs"); // [RL6]

    property p_hold_float;
        @(posedge CORE_CLK) disable iff (RESET)
        ADDR_HOLD_REQ |=> !PHYS_ADDR_OE && !ADDR_PARITY_OE;
    endproperty
    a_hold_float: assert property (p_hold_float) else $error("address driven under hold"); // [RL7]

    property p_be_hold;
        @(posedge CORE_CLK) disable iff (RESET)
        ADDR_HOLD_REQ && !float_all && !BUS_HOLD_REQ |=> BYTE_LANE_OE;
    endproperty
    a_be_hold: assert property (p_be_hold) else $error("lanes floated by hold"); // [RL17]

    property p_bus_backoff_n_float;
        @(posedge CORE_CLK) disable iff (RESET)
        bus_backoff_n |=> !CYCLE_STROBE_OE && !PHYS_ADDR_OE && !BYTE_LANE_OE && !DATA_OE && !CYCLE_DEF_OE;
    endproperty
    a_bus_backoff_n_float: assert property (p_bus_backoff_n_float) else $error("driven during backoff"); // [RL20]

    property p_bus_backoff_n_ack;
        @(posedge CORE_CLK) disable iff (RESET)
        bus_backoff_n && state_r == CBC_ACT |=> state_r == CBC_BUS_BACKOFF_N && ack_cnt_r == CBC_CNT_RST;
    endproperty
    a_bus_backoff_n_ack: assert property (p_bus_backoff_n_ack) else $error("ack not discarded on backoff"); // [RL22]

    property p_perr;
        @(posedge CORE_CLK) disable iff (RESET)
        !SNOOP_ADDR_VALID_N && ^{SNOOP_PARITY_IN, SNOOP_ADDR} |-> ##2 !ADDR_PARITY_ERR_N;
    endproperty
    a_perr: assert property (p_perr) else $error("parity error not flagged"); // [RL14]

    property p_par;
        @(posedge CORE_CLK) disable iff (RESET)
        $fell(CYCLE_STROBE_N) |-> ^{ADDR_PARITY_BIT, PHYS_ADDR[31:CBC_PAR_LO]} == 1'b0;
    endproperty
    a_par: assert property (p_par) else $error("address parity odd"); // [RL10]

    property p_addr_hold_req_start;
        @(posedge CORE_CLK) disable iff (RESET)
        start && ADDR_HOLD_REQ |-> REQ.wb;
    endproperty
    a_addr_hold_req_start: assert property (p_addr_hold_req_start) else $error("non writeback under hold"); // [RL4]

    property p_ratio;
        @(posedge CORE_CLK) disable iff (RESET)
        !rst_d_r && hold_cnt_r == CBC_CNT_RST |=> $stable(ratio_r);
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio changed"); // [RL24]

endmodule

/* verif/cbc_sys_model.sv */
// Chipset side model: acknowledges each bus cycle
// Assumes strobe, backoff and burst are seen on CORE_CLK
`timescale 1ns/1ps
module cbc_sys_model
    import cbc_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RESET,
    input  wire logic       CYCLE_STROBE_N,
    input  wire logic       CYCLE_STROBE_OE,
    input  wire logic       BUS_BACKOFF_N,
    input  wire logic       BURST,
    input  wire logic [1:0] SLOW,
    output logic            TRANSFER_ACK_N
);
    logic [2:0] left_r;
    logic [1:0] dly_r;
    // ==========================
    // Acknowledge sequencer, line idles high
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            left_r         <= CBC_CNT_RST;
            dly_r          <= 2'h0;
            TRANSFER_ACK_N <= 1'b1;
        end
        else if (!BUS_BACKOFF_N)
        begin
            left_r         <= CBC_CNT_RST;
            TRANSFER_ACK_N <= 1'b1;
        end
        else if (CYCLE_STROBE_OE && !CYCLE_STROBE_N)
        begin
            left_r         <= BURST ? CBC_XFER_BURST : CBC_XFER_SINGLE;
            dly_r          <= SLOW;
            TRANSFER_ACK_N <= 1'b1;
        end
        else if (left_r != CBC_CNT_RST && dly_r == 2'h0)
        begin
            left_r         <= left_r - 3'h1;
            dly_r          <= SLOW;
            TRANSFER_ACK_N <= 1'b0;
        end
        else
        begin
            dly_r          <= (dly_r != 2'h0) ? dly_r - 2'h1 : dly_r;
            TRANSFER_ACK_N <= 1'b1;
        end
    end
endmodule

/* verif/cbc_top_test.sv */
// Testbench for the bus cycle control block
// Assumes cbc_sys_model on the far side; assertions sit in the design
`timescale 1ns/1ps
module cbc_top_test
    import cbc_pkg::*;
;
    logic        clk, rst, rq_v, hold, bus_backoff_n_n, bhold, na_n, snp_n, snp_par, burst;
    logic        rdy, done, stb_n, stb_oe, stbc_n, stbc_oe, a_oe, par, par_oe;
    logic        be_oe, def_oe, d_oe, bus_hold_ack, perr_n, ack_n, fin_r, stb_r;
    cbc_req_s    rq, r;
    logic [31:5] snp_a;
    logic [31:3] addr;
    logic [7:0]  be_n;
    logic [3:0]  def, mult;
    logic [2:0]  ratio, exp_r;
    logic [1:0]  slow;
    int          n_mismatch, checked, nack, n_done;

    cbc_top DUT (
        .CORE_CLK(clk), .RESET(rst), .REQ_VALID(rq_v), .REQ(rq), .ADDR_HOLD_REQ(hold),
        .BUS_BACKOFF_N(bus_backoff_n_n), .BUS_HOLD_REQ(bhold), .TRANSFER_ACK_N(ack_n),
        .NEXT_ADDR_REQ_N(na_n), .SNOOP_ADDR_VALID_N(snp_n), .SNOOP_ADDR(snp_a),
        .SNOOP_PARITY_IN(snp_par), .CORE_RATIO_SEL(ratio), .REQ_READY(rdy), .REQ_DONE(done),
        .CYCLE_STROBE_N(stb_n), .CYCLE_STROBE_OE(stb_oe), .CYCLE_STROBE_COPY_N(stbc_n),
        .CYCLE_STROBE_COPY_OE(stbc_oe), .PHYS_ADDR(addr), .PHYS_ADDR_OE(a_oe),
        .ADDR_PARITY_BIT(par), .ADDR_PARITY_OE(par_oe), .BYTE_LANE_EN_N(be_n),
        .BYTE_LANE_OE(be_oe), .CYCLE_DEF(def), .CYCLE_DEF_OE(def_oe), .DATA_OE(d_oe),
        .BUS_HOLD_ACK(bus_hold_ack), .ADDR_PARITY_ERR_N(perr_n), .CORE_MULT_HALVES(mult)
    );

    cbc_sys_model SYS (
        .CORE_CLK(clk), .RESET(rst), .CYCLE_STROBE_N(stb_n), .CYCLE_STROBE_OE(stb_oe),
        .BUS_BACKOFF_N(bus_backoff_n_n), .BURST(burst), .SLOW(slow), .TRANSFER_ACK_N(ack_n)
    );

    always #5 clk = ~clk;

    // ==========================
    // Bus monitor
    always @(posedge clk)
    begin
        if (stb_oe && !stb_n)
        begin
            if (fin_r || stb_r)
            begin
                n_mismatch++;
                $display("wrong value strobe gap exp 1 got 0");
            end
            nack <= 0;
            exp_r <= burst ? 3'h4 : 3'h1;
        end
        else if (!ack_n && bus_backoff_n_n)
            nack <= nack + 1;
        fin_r <= !ack_n && bus_backoff_n_n && (nack + 1 == int'(exp_r));
        stb_r <= stb_oe && !stb_n;
        if (done)
            n_done <= n_done + 1;
    end

    // ==========================
    // Helpers
    function automatic logic par_of(input logic [31:5] a);
        return ^a;
    endfunction

    function automatic logic [3:0] mult_of(input logic [2:0] s);
        case (s)
            3'h4: return 4'h5;
            3'h5: return 4'h6;
            3'h6: return 4'hC;
            3'h7: return 4'h7;
            3'h0: return 4'h9;
            3'h1: return 4'hA;
            3'h2: return 4'h8;
            default: return 4'hB;
        endcase
    endfunction

    function automatic cbc_req_s rnd_req(input logic wb);
        cbc_req_s q;
        q.addr = 29'($urandom);
        q.be_n = 8'($urandom);
        q.def = 4'($urandom);
        q.burst = 1'($urandom);
        q.wb = wb;
        return q;
    endfunction

    function automatic logic sig(input int k);
        case (k)
            0: return stb_oe && !stb_n;
            1: return done;
            2: return bus_hold_ack;
            3: return !ack_n;
            default: return !bus_hold_ack;
        endcase
    endfunction

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask

    task automatic wait_sig(input int k);
        int i;
        i = 0;
        while (sig(k) !== 1'b1 && i < 60)
        begin
            i++;
            tick;
        end
        if (i == 60)
        begin
            n_mismatch++;
            $display("wrong value wait %0d exp 1 got 0", k);
            test_done;
        end
    endtask

    task automatic chk_start(input cbc_req_s q);
        if (!hold)
            chk("addr", 32'(q.addr), 32'(addr));
        if (!hold)
            chk("par", 32'(par_of(q.addr[31:5])), 32'(par));
        chk("be", 32'(q.be_n), 32'(be_n));
        chk("def", 32'(q.def), 32'(def));
        chk("copy", 32'({stb_n, stb_oe}), 32'({stbc_n, stbc_oe}));
        chk("oe", 32'({!hold, !hold, 2'h3}), 32'({a_oe, par_oe, be_oe, def_oe}));
    endtask

    task automatic start(input cbc_req_s q);
        rq = q;
        burst = q.burst;
        rq_v = 1'b1;
        wait_sig(0);
        rq_v = 1'b0;
        chk_start(q);
    endtask

    task automatic finish(input cbc_req_s q);
        wait_sig(1);
        tick;
        chk("acks", q.burst ? 32'h4 : 32'h1, 32'(nack));
    endtask

    task automatic snoop(input logic bad);
        snp_a = 27'($urandom);
        snp_par = par_of(snp_a) ^ bad;
        snp_n = 1'b0;
        tick;
        snp_n = 1'b1;
        snp_a = ~snp_a;
        snp_par = ~snp_par;
        chk("perr", 32'h1, 32'(perr_n));
        tick;
        chk("perr", 32'(!bad), 32'(perr_n));
        tick;
        chk("perr", 32'h1, 32'(perr_n));
    endtask

    // ==========================
    // Main sequence
    initial
    begin
        {clk, rq_v, hold, bhold, snp_par, burst, fin_r, stb_r} = '0;
        {rst, bus_backoff_n_n, na_n, snp_n} = 4'hF;
        {n_mismatch, checked, nack, n_done} = '0;
        rq = '0;
        snp_a = '0;
        ratio = CBC_R_3P5;
        slow = 2'h0;
        exp_r = 3'h1;
        void'($urandom(23));
        for (int k = 0; k < 8; k++)
        begin
            ratio = 3'(k);
            rst = 1'b1;
            repeat (10) tick;
            rst = 1'b0;
            repeat (2) tick;
            ratio = ~ratio;
            repeat (3) tick;
            chk("mult", 32'(mult_of(3'(k))), 32'(mult));
        end
        r = rnd_req(1'b0);
        rq = r;
        burst = r.burst;
        rq_v = 1'b1;
        repeat (24)
        begin
            wait_sig(0);
            chk_start(r);
            tick;
            r = rnd_req(1'b0);
            slow = 2'($urandom);
            rq = r;
            burst = r.burst;
        end
        wait_sig(0);
        rq_v = 1'b0;
        chk_start(r);
        finish(r);
        chk("done count", 32'd25, 32'(n_done));
        r = rnd_req(1'b0);
        r.burst = 1'b1;
        slow = 2'h1;
        start(r);
        wait_sig(3);
        bus_backoff_n_n = 1'b0;
        tick;
        chk("bus_backoff_n oe", 32'h0, 32'({stb_oe, stbc_oe, a_oe, par_oe, be_oe, def_oe, d_oe}));
        repeat (2) tick;
        bus_backoff_n_n = 1'b1;
        wait_sig(0);
        chk_start(r);
        finish(r);
        r = rnd_req(1'b0);
        start(r);
        hold = 1'b1;
        tick;
        chk("hold oe", 32'h1, 32'({a_oe, par_oe, be_oe}));
        finish(r);
        for (int k = 0; k < 4; k++)
            snoop(k[0]);
        r = rnd_req(1'b0);
        rq = r;
        rq_v = 1'b1;
        repeat (6) tick;
        chk("no start", 32'd27, 32'(n_done));
        chk("no strobe", 32'h0, 32'(stb_r));
        r.wb = 1'b1;
        start(r);
        finish(r);
        hold = 1'b0;
        tick;
        chk("hold off", 32'h3, 32'({a_oe, par_oe}));
        bhold = 1'b1;
        wait_sig(2);
        chk("bus_hold_ack oe", 32'h0, 32'({stb_oe, a_oe, par_oe, be_oe}));
        bhold = 1'b0;
        wait_sig(4);
        chk("bus_hold_ack off", 32'h3, 32'({a_oe, par_oe}));
        test_done;
    end
endmodule
